// ===== rtl/acr_config_top.sv
// Setup register with serial access and the control it drives.
// Assumes host shift strobes are synchronous to clk_i; each cycle with shift high moves one bit.
`timescale 1ns/1ps
`default_nettype none
module acr_config_top
	import acr_pkg::*;
#(
	parameter int CONV_NOCHOP = CONV_NOCHOP_CYC,
	parameter int SETL_NOCHOP = SETL_NOCHOP_CYC,
	parameter int CONV_CHOP   = CONV_CHOP_CYC,
	parameter int SETL_CHOP   = SETL_CHOP_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        sel_i,
	input  wire logic        rd_i,
	input  wire logic        shift_i,
	input  wire logic        sdi_i,
	output logic             sdo_o,
	input  wire logic        run_i,
	input  wire logic [9:0]  rate_divider_word_i,
	input  wire logic        cal_internal_i,
	input  wire logic        sample_strobe_i,
	output logic [23:0]      setup_word_o,
	output logic             chop_enable_o,
	output logic             alt_excitation_active_o,
	output logic             polarity_swap_o,
	output logic [7:0]       channel_enable_bits_o,
	output logic             buffer_enable_o,
	output logic             open_sense_current_enable_o,
	output logic             conv_done_o,
	output logic [2:0]       conv_channel_o
);
	typedef struct packed {
		logic [23:0] cfg;
		logic [23:0] sh;
		logic [4:0]  bitcnt;
		logic        sel_d;
		logic        swap;
		logic        open_sense_current_enable;
	} acr_top_s;

	acr_top_s  st_reg;
	acr_top_s  st_next;
	logic      alt_active;
	acr_seq_if seq_bus ();

	assign alt_active = st_reg.cfg[BIT_ALT_EXC] && !cal_internal_i;

	// Serial access, polarity swap and current interlock
	always_comb begin
		st_next       = st_reg;
		st_next.sel_d = sel_i;
		if (sel_i && !st_reg.sel_d) begin
			st_next.bitcnt = 5'h0;
			st_next.sh     = rd_i ? st_reg.cfg : 24'h0;
		end else if (sel_i && shift_i) begin
			st_next.sh     = {st_reg.sh[22:0], rd_i ? 1'b0 : sdi_i};
			st_next.bitcnt = st_reg.bitcnt + 5'h1;
			if (!rd_i && st_reg.bitcnt == LAST_BIT) begin
				st_next.cfg = {st_reg.sh[22:0], sdi_i} & CFG_WRITE_MASK;
			end
		end
		if (!alt_active) st_next.swap = 1'b0;
		else if (sample_strobe_i) st_next.swap = !st_reg.swap;
		// currents need buffer and no chop
		st_next.open_sense_current_enable = st_next.cfg[BIT_OPEN_SENSE] && st_next.cfg[BIT_BUFFER] && !st_next.cfg[BIT_CHOP];
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_reg <= '{cfg: CFG_RESET, sh: 24'h0, bitcnt: 5'h0, sel_d: 1'b0, swap: 1'b0, open_sense_current_enable: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Sequencer connection
	assign seq_bus.chan_en = st_reg.cfg[CH_MSB:CH_LSB];
	assign seq_bus.chop    = st_reg.cfg[BIT_CHOP];
	assign seq_bus.run     = run_i;
	assign seq_bus.fs      = rate_divider_word_i;

	acr_sequencer #(
		.CONV_NOCHOP (CONV_NOCHOP),
		.SETL_NOCHOP (SETL_NOCHOP),
		.CONV_CHOP   (CONV_CHOP),
		.SETL_CHOP   (SETL_CHOP)
	) u_seq (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.bus     (seq_bus.seq)
	);

	// Outputs
	assign sdo_o                       = st_reg.sh[23];
	assign setup_word_o                = st_reg.cfg;
	assign chop_enable_o               = st_reg.cfg[BIT_CHOP];
	assign alt_excitation_active_o     = alt_active;
	assign polarity_swap_o             = st_reg.swap;
	assign channel_enable_bits_o       = st_reg.cfg[CH_MSB:CH_LSB];
	assign buffer_enable_o             = st_reg.cfg[BIT_BUFFER];
	assign open_sense_current_enable_o = st_reg.open_sense_current_enable;
	assign conv_done_o                 = seq_bus.done;
	assign conv_channel_o              = seq_bus.chan;

	reset_value_a: assert property (@(posedge clk_i) disable iff (reset_i)
		$fell(reset_i) |-> (setup_word_o == CFG_RESET && !open_sense_current_enable_o))
		else $error("setup word not at reset value");
	write_commit_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(sel_i && st_reg.sel_d && shift_i && !rd_i && st_reg.bitcnt == LAST_BIT)
		|=> setup_word_o == (($past(st_reg.sh) << 1 | 24'($past(sdi_i))) & CFG_WRITE_MASK))
		else $error("write not committed");
	open_sense_current_enable_lock_a: assert property (@(posedge clk_i) disable iff (reset_i)
		open_sense_current_enable_o |-> (buffer_enable_o && !chop_enable_o))
		else $error("currents on outside allowed setup");
	open_sense_current_enable_on_a: assert property (@(posedge clk_i) disable iff (reset_i)
		open_sense_current_enable_o == (setup_word_o[BIT_OPEN_SENSE] && buffer_enable_o && !chop_enable_o))
		else $error("currents do not follow setup");
	cal_dc_a: assert property (@(posedge clk_i) disable iff (reset_i)
		cal_internal_i |=> !polarity_swap_o)
		else $error("polarity swapped during calibration");
	swap_toggle_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(alt_active && sample_strobe_i) |=> polarity_swap_o != $past(polarity_swap_o))
		else $error("polarity did not alternate");
	// chop changes only through a completed write
	chop_link_a: assert property (@(posedge clk_i) disable iff (reset_i)
		$changed(chop_enable_o) |-> $past(sel_i && st_reg.sel_d && shift_i && !rd_i && st_reg.bitcnt == LAST_BIT))
		else $error("chop enable changed without a write");
endmodule : acr_config_top
`default_nettype wire

// ===== rtl/acr_pkg.sv
// Constants for the converter setup register and its channel sequencer.
// Assumes one 25 MHz clock and a synchronous, active-high reset.
// Functional notes
// - Top setup bit enables offset chopping.
// - Chop on, word 96: 80/160 ms.
// - Chop off, word 96: 20/80 ms.
// - Excitation on: swap polarity each sample.
// - Internal calibrations ignore the excitation bit.
// - Bits 15..8 enable channels, auto-sequenced.
// - Each sequenced channel waits full settling.
// - Bit 7 switches open-sensor currents.
// - Currents only with buffer, chopping off.
// - 24-bit register, MSB first, resets 0x000117.
package acr_pkg;
	localparam int          CFG_W          = 24;
	localparam logic [23:0] CFG_RESET      = 24'h000117;
	// Reserved positions 21..16 and 5 always read back as zero
	localparam logic [23:0] CFG_WRITE_MASK = 24'hC0FFDF;
	localparam int          BIT_CHOP       = 23;
	localparam int          BIT_ALT_EXC    = 22;
	localparam int          CH_MSB         = 15;
	localparam int          CH_LSB         = 8;
	localparam int          BIT_OPEN_SENSE = 7;
	localparam int          BIT_BUFFER     = 4;
	localparam int          NUM_CH         = 8;
	localparam int          FS_W           = 10;
	localparam logic [4:0]  LAST_BIT       = 5'h17;
	// Timing at the reference rate divider word
	localparam int          CLK_HZ         = 25000000;
	localparam int          FS_REF         = 96;
	localparam int          CONV_NOCHOP_MS = 20;
	localparam int          SETL_NOCHOP_MS = 80;
	localparam int          CONV_CHOP_MS   = 80;
	localparam int          SETL_CHOP_MS   = 160;
	localparam int          CONV_NOCHOP_CYC = CONV_NOCHOP_MS * (CLK_HZ / 1000);
	localparam int          SETL_NOCHOP_CYC = SETL_NOCHOP_MS * (CLK_HZ / 1000);
	localparam int          CONV_CHOP_CYC   = CONV_CHOP_MS * (CLK_HZ / 1000);
	localparam int          SETL_CHOP_CYC   = SETL_CHOP_MS * (CLK_HZ / 1000);
	typedef enum logic [2:0] {
		ACR_IDLE    = 3'b001,
		ACR_SETTLE  = 3'b010,
		ACR_CONVERT = 3'b100
	} acr_seq_state_e;
	// Next enabled channel above cur, wrapping; cur itself if alone
	function automatic logic [2:0] acr_next_ch(input logic [7:0] mask, input logic [2:0] cur);
		logic [2:0] idx;
		logic [2:0] res;
		logic       found;
		res   = cur;
		found = 1'b0;
		for (int i = 1; i <= NUM_CH; i++) begin
			idx = 3'(cur + 3'(i));
			if (!found && mask[idx]) begin
				res   = idx;
				found = 1'b1;
			end
		end
		return res;
	endfunction : acr_next_ch
endpackage : acr_pkg

// ===== rtl/acr_seq_if.sv
// Link between the setup register and the channel sequencer.
// Assumes both ends share clk_i of the top module.
`timescale 1ns/1ps
`default_nettype none
interface acr_seq_if;
	logic [7:0] chan_en;
	logic       chop;
	logic       run;
	logic [9:0] fs;
	logic       done;
	logic [2:0] chan;
	modport ctl (output chan_en, chop, run, fs, input done, chan);
	modport seq (input chan_en, chop, run, fs, output done, chan);
endinterface : acr_seq_if
`default_nettype wire

// ===== rtl/acr_sequencer.sv
// Channel sequencer with settling and conversion timers.
// Assumes the setup word is stable while a conversion runs.
`timescale 1ns/1ps
`default_nettype none
module acr_sequencer
	import acr_pkg::*;
#(
	parameter int CONV_NOCHOP = CONV_NOCHOP_CYC,
	parameter int SETL_NOCHOP = SETL_NOCHOP_CYC,
	parameter int CONV_CHOP   = CONV_CHOP_CYC,
	parameter int SETL_CHOP   = SETL_CHOP_CYC
) (
	input  wire logic clk_i,
	input  wire logic reset_i,
	acr_seq_if.seq    bus
);
	typedef struct packed {
		acr_seq_state_e state;
		logic [2:0]     ch;
		logic [31:0]    cnt;
		logic           done;
	} acr_seq_s;

	acr_seq_s   st_reg;
	acr_seq_s   st_next;
	logic [31:0] setl_tgt;
	logic [31:0] conv_tgt;
	logic        multi;
	logic [2:0]  nxt_ch;

	// Timer targets scale with the rate divider word; multiply first so word 96 is exact
	always_comb begin
		setl_tgt = 32'((64'(bus.chop ? SETL_CHOP : SETL_NOCHOP) * 64'(bus.fs)) / 64'(FS_REF));
		conv_tgt = 32'((64'(bus.chop ? CONV_CHOP : CONV_NOCHOP) * 64'(bus.fs)) / 64'(FS_REF));
		if (setl_tgt == 32'h0) setl_tgt = 32'h1;
		if (conv_tgt == 32'h0) conv_tgt = 32'h1;
		multi  = (bus.chan_en & (bus.chan_en - 8'h01)) != 8'h00;
		nxt_ch = acr_next_ch(bus.chan_en, st_reg.ch);
	end

	// Sequencing state machine
	always_comb begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		case (st_reg.state)
			ACR_IDLE: begin
				st_next.ch  = acr_next_ch(bus.chan_en, 3'h7);
				st_next.cnt = 32'h0;
				if (bus.run && bus.chan_en != 8'h00) st_next.state = ACR_SETTLE;
			end
			ACR_SETTLE: begin
				st_next.cnt = st_reg.cnt + 32'h1;
				if (st_reg.cnt >= setl_tgt - 32'h1) begin
					st_next.done = 1'b1;
					st_next.cnt  = 32'h0;
					if (multi) st_next.ch = nxt_ch;
					else st_next.state = ACR_CONVERT;
				end
			end
			ACR_CONVERT: begin
				st_next.cnt = st_reg.cnt + 32'h1;
				if (st_reg.cnt >= conv_tgt - 32'h1) begin
					st_next.done = 1'b1;
					st_next.cnt  = 32'h0;
				end
				if (multi) st_next.state = ACR_SETTLE;
			end
			default: st_next.state = ACR_IDLE;
		endcase
		// Stopping or dropping the channel aborts without a result
		if (!bus.run || !bus.chan_en[st_reg.ch]) begin
			st_next.state = ACR_IDLE;
			st_next.done  = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_reg <= '{state: ACR_IDLE, ch: 3'h0, cnt: 32'h0, done: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus.done = st_reg.done;
	assign bus.chan = st_reg.ch;

	done_chan_en_a: assert property (@(posedge clk_i) disable iff (reset_i)
		st_next.done |-> bus.chan_en[st_reg.ch])
		else $error("result on a disabled channel");
	seq_order_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(st_reg.state == ACR_SETTLE && st_next.done && multi && bus.run && bus.chan_en[st_reg.ch])
		|=> bus.chan == $past(nxt_ch))
		else $error("channel order wrong");
	multi_settle_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(st_next.done && multi) |-> (st_reg.state == ACR_SETTLE && st_reg.cnt >= setl_tgt - 32'h1))
		else $error("sequenced result before settling");
	chop_timing_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(bus.chop && bus.fs == 10'h060) |-> (setl_tgt == 32'(SETL_CHOP) && conv_tgt == 32'(CONV_CHOP)))
		else $error("chop timing off");
	nochop_timing_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(!bus.chop && bus.fs == 10'h060) |-> (setl_tgt == 32'(SETL_NOCHOP) && conv_tgt == 32'(CONV_NOCHOP)))
		else $error("non-chop timing off");
endmodule : acr_sequencer
`default_nettype wire

// ===== dv/acr_host_model.sv
// Host controller model for the serial setup port.
// Assumes the device samples select, shift and data on rising clk_i.
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
	input  wire logic clk_i,
	input  wire logic sdo_i,
	output var logic  sel_o,
	output var logic  rd_o,
	output var logic  shift_o,
	output var logic  sdi_o
);
	// Idle port
	initial begin
		sel_o   = 1'b0;
		rd_o    = 1'b0;
		shift_o = 1'b0;
		sdi_o   = 1'b0;
	end
	// callers pass legal words, save mask and interlock probes
	// One full frame, MSB first; read bits taken before each shift lands
	task automatic xfer(input logic rd, input logic [23:0] w, output logic [23:0] r);
		@(posedge clk_i);
		sel_o <= 1'b1;
		rd_o  <= rd;
		@(posedge clk_i);
		for (int i = 23; i >= 0; i--) begin
			shift_o <= 1'b1;
			sdi_o   <= w[i];
			// Sample the settled read bit away from the shifting edge
			@(negedge clk_i);
			r[i] = sdo_i;
			@(posedge clk_i);
		end
		shift_o <= 1'b0;
		sel_o   <= 1'b0;
		sdi_o   <= ~w[0]; // Released line no longer holds its bit
		@(posedge clk_i);
	endtask : xfer
endmodule : acr_host_model
`default_nettype wire

// ===== dv/test_adc_config_register_control.sv
// Self-checking bench for the setup register and channel sequencer.
// Assumes short timer parameters so word 96 gives 96/384/384/768 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_adc_config_register_control
	import acr_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        sel, rd, shift, sdi, sdo, done, chop, alt, swap, buf_en, osc;
	logic        run_i = 1'b0;
	logic        cal_i = 1'b0;
	logic        strobe_i = 1'b0;
	logic [9:0]  rate_i = 10'h060;
	logic [23:0] word;
	logic [7:0]  chen;
	logic [2:0]  chan;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          cyc = 0;
	// Clock and hang guard
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			end_sim();
		end
	end
	acr_config_top #(.CONV_NOCHOP(96), .SETL_NOCHOP(384), .CONV_CHOP(384), .SETL_CHOP(768)) uut (
		.clk_i(clk_i), .reset_i(reset_i), .sel_i(sel), .rd_i(rd), .shift_i(shift), .sdi_i(sdi),
		.sdo_o(sdo), .run_i(run_i), .rate_divider_word_i(rate_i), .cal_internal_i(cal_i),
		.sample_strobe_i(strobe_i), .setup_word_o(word), .chop_enable_o(chop),
		.alt_excitation_active_o(alt), .polarity_swap_o(swap), .channel_enable_bits_o(chen),
		.buffer_enable_o(buf_en), .open_sense_current_enable_o(osc), .conv_done_o(done),
		.conv_channel_o(chan));
	acr_host_model host (.clk_i(clk_i), .sdo_i(sdo), .sel_o(sel), .rd_o(rd), .shift_o(shift), .sdi_o(sdi));
	// Compare and count
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic wr(input logic [23:0] w);
		logic [23:0] r;
		host.xfer(1'b0, w, r);
		@(posedge clk_i);
	endtask : wr
	// Cycles up to the next result pulse, bounded
	task automatic wait_done(output int n);
		logic hit;
		n = 0;
		do begin
			// Look at the pulse mid-cycle, then step to the next rising edge
			@(negedge clk_i);
			hit = (done === 1'b1);
			@(posedge clk_i);
			n++;
		end while (!hit && n < 2000);
	endtask : wait_done
	task automatic t_reset();
		check(word, 24'h000117);
		check({chop, osc, done, swap, buf_en, chen, chan}, {5'h01, 8'h01, 3'h0});
		$display("t_reset done");
	endtask : t_reset
	task automatic t_serial();
		logic [23:0] r;
		wr(24'hFFFFFF);
		check(word, 24'hC0FFDF);
		host.xfer(1'b1, 24'h5A5A5A, r);
		check(r, 24'hC0FFDF);
		check({chop, chen, osc}, {1'b1, 8'hFF, 1'b0});
		$display("t_serial done");
	endtask : t_serial
	task automatic t_open_sense_current_enable();
		wr(24'h000190);
		check(osc, 1'b1);
		wr(24'h000180);
		check(osc, 1'b0);
		wr(24'h800190);
		check(osc, 1'b0);
		wr(24'h000110);
		check({chop, osc}, 2'h0);
		$display("t_open_sense_current_enable done");
	endtask : t_open_sense_current_enable
	task automatic t_exc();
		logic s;
		wr(24'hC00110);
		check(alt, 1'b1);
		s = swap;
		for (int i = 0; i < 3; i++) begin
			strobe_i <= 1'b1;
			@(posedge clk_i);
			strobe_i <= 1'b0;
			repeat (2) @(posedge clk_i);
			check(swap, s ^ !i[0]);
		end
		// Swap is high here; calibration with strobes must force it low
		cal_i    <= 1'b1;
		strobe_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check({alt, swap}, 2'h0);
		cal_i    <= 1'b0;
		strobe_i <= 1'b0;
		$display("t_exc done");
	endtask : t_exc
	task automatic t_time(input logic [23:0] w, input int tc, input int ts);
		int n;
		wr(w);
		run_i <= 1'b1;
		wait_done(n);
		check(24'(n >= ts && n <= ts + 3), 24'h1);
		wait_done(n);
		check(24'(n >= tc && n <= tc + 2), 24'h1);
		run_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		$display("t_time done");
	endtask : t_time
	task automatic t_multi();
		int         n;
		logic [2:0] p, e;
		wr(24'h004A10);
		run_i <= 1'b1;
		wait_done(n);
		p = chan;
		for (int i = 0; i < 4; i++) begin
			wait_done(n);
			e = (p == 3'h1) ? 3'h3 : (p == 3'h3) ? 3'h6 : 3'h1;
			check(24'(n >= 384 && n <= 386), 24'h1);
			check(24'(chan), 24'(e));
			p = chan;
		end
		run_i <= 1'b0;
		$display("t_multi done");
	endtask : t_multi
	// Reset in the middle of a sequencing run
	task automatic t_rst_mid();
		wr(24'h004A10);
		run_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
		check(word, 24'h000117);
		check({sdo, chop, done, osc, chan}, 7'h00);
		@(posedge clk_i);
		run_i <= 1'b0;
		$display("t_rst_mid done");
	endtask : t_rst_mid
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_serial();
		t_open_sense_current_enable();
		t_exc();
		t_time(24'h000110, 96, 384);
		t_time(24'h800110, 384, 768);
		t_multi();
		t_rst_mid();
		end_sim();
	end
endmodule : test_adc_config_register_control
`default_nettype wire
